// >>> rtl/tmrs_consts.svh
`ifndef TMRS_CONSTS_SVH
`define TMRS_CONSTS_SVH

// ==========================================================
// register offsets
`define TMRS_OFS_FIRST_LOW   8'h8a
`define TMRS_OFS_SECOND_LOW  8'h8b
`define TMRS_OFS_T3_CTRL     8'h91
`define TMRS_OFS_RELOAD_LOW  8'hca
`define TMRS_OFS_RELOAD_HIGH 8'hcb

// ==========================================================
// fourth timer control field positions
`define TMRS_BIT_HIGH_OVF    7
`define TMRS_BIT_LOW_OVF     6
`define TMRS_BIT_LOW_IRQ_EN  5
`define TMRS_BIT_CAPTURE_EN  4
`define TMRS_BIT_SPLIT       3
`define TMRS_BIT_RUN         2
`define TMRS_BIT_XCLK_HI     1
`define TMRS_BIT_XCLK_LO     0

// ==========================================================
// reset values
`define TMRS_RST_BYTE        8'h00
`define TMRS_RST_READ        8'h00

`endif

// >>> rtl/tmrs_pkg.sv
// ==========================================================
// shared types
package tmrs_pkg;
	typedef logic [7:0] tmrs_byte_t;

	// fourth timer operating mode, one-hot
	typedef enum logic [1:0] {
		TMRS_MODE_WIDE  = 2'b01,
		TMRS_MODE_SPLIT = 2'b10
	} tmrs_mode_e;
endpackage : tmrs_pkg

// >>> rtl/tmrs_cnt8.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// one count byte with reload
module tmrs_cnt8 #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// control
	input  wire logic         inc,
	input  wire logic         reload_en,
	input  wire logic [W-1:0] reload_val,
	// state
	output logic      [W-1:0] count_q,
	output logic              at_max
);
	logic [W-1:0] count_d;

	assign at_max = &count_q;

	// reload beats increment: it replaces the wrap to zero
	always_comb begin
		count_d = count_q;
		if (reload_en) begin
			count_d = reload_val;
		end else if (inc) begin
			count_d = W'(count_q + 1'b1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule : tmrs_cnt8

`default_nettype wire

// >>> rtl/tmrs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmrs_consts.svh"

// How it works
// - first timer low count byte, rw, resets zero
// - third timer reload low byte, rw, zero
// - third timer reload high byte, rw, zero
// - high byte wrap sets high overflow flag
// - sixteen-bit wrap sets high overflow flag
// - enabled timer interrupt requests on high flag
// - high flag cleared only by software
// - low byte wrap always sets low flag
// - low flag interrupts when both enables set
// - split select: one 16-bit or two 8-bit
// - run gates timer; split gates high only
module tmrs_top (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// special-function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata_q,
	// third timer count source
	input  wire logic       third_tick,
	input  wire logic       third_run,
	// fourth timer count source and reload
	input  wire logic       fourth_tick,
	input  wire logic [7:0] fourth_reload_low,
	input  wire logic [7:0] fourth_reload_high,
	input  wire logic       fourth_irq_enable,
	// register contents to the rest of the timer set
	output logic      [7:0] first_timer_low_count_q,
	output logic      [7:0] second_timer_low_count_q,
	output logic      [1:0] external_clock_select_q,
	output logic            capture_mode_enable_q,
	// counts and interrupt
	output logic     [15:0] third_count_q,
	output logic      [7:0] fourth_timer_low_byte_q,
	output logic      [7:0] fourth_timer_high_byte_q,
	output logic            fourth_irq_q
);

	// ==========================================================
	// register file state
	tmrs_pkg::tmrs_byte_t first_low_d;
	tmrs_pkg::tmrs_byte_t second_low_d;
	tmrs_pkg::tmrs_byte_t reload_value_low_q;
	tmrs_pkg::tmrs_byte_t reload_value_low_d;
	tmrs_pkg::tmrs_byte_t reload_value_high_q;
	tmrs_pkg::tmrs_byte_t reload_value_high_d;
	logic                 high_overflow_flag_q;
	logic                 high_overflow_flag_d;
	logic                 low_overflow_flag_q;
	logic                 low_overflow_flag_d;
	logic                 low_overflow_irq_enable_q;
	logic                 low_overflow_irq_enable_d;
	logic                 capture_d;
	logic                 split_mode_select_q;
	logic                 split_mode_select_d;
	logic                 run_control_q;
	logic                 run_control_d;
	logic           [1:0] xclk_d;
	tmrs_pkg::tmrs_byte_t rdata_d;
	logic                 irq_d;
	tmrs_pkg::tmrs_mode_e mode;

	// ==========================================================
	// counter wiring
	logic       third_low_inc;
	logic       third_high_inc;
	logic       third_wrap;
	logic       third_low_max;
	logic       third_high_max;
	logic [7:0] third_low_q;
	logic [7:0] third_high_q;
	logic       fourth_low_inc;
	logic       fourth_high_inc;
	logic       fourth_low_wrap;
	logic       fourth_high_wrap;
	logic       fourth_low_reload;
	logic       fourth_high_reload;
	logic       fourth_low_max;
	logic       fourth_high_max;

	// ==========================================================
	// write decode
	logic wr_first;
	logic wr_second;
	logic wr_ctrl;
	logic wr_rl_low;
	logic wr_rl_high;

	assign wr_first   = sfr_wr && (sfr_addr == `TMRS_OFS_FIRST_LOW);
	assign wr_second  = sfr_wr && (sfr_addr == `TMRS_OFS_SECOND_LOW);
	assign wr_ctrl    = sfr_wr && (sfr_addr == `TMRS_OFS_T3_CTRL);
	assign wr_rl_low  = sfr_wr && (sfr_addr == `TMRS_OFS_RELOAD_LOW);
	assign wr_rl_high = sfr_wr && (sfr_addr == `TMRS_OFS_RELOAD_HIGH);

	assign mode = split_mode_select_q ? tmrs_pkg::TMRS_MODE_SPLIT
	                                  : tmrs_pkg::TMRS_MODE_WIDE;

	// ==========================================================
	// third timer: 16-bit auto-reload
	assign third_low_inc  = third_tick && third_run;
	assign third_high_inc = third_low_inc && third_low_max;
	assign third_wrap     = third_high_inc && third_high_max;

	tmrs_cnt8 #(.W(8)) u_third_low (
		.clk        (clk),
		.nrst       (nrst),
		.inc        (third_low_inc),
		.reload_en  (third_wrap),
		.reload_val (reload_value_low_q),
		.count_q    (third_low_q),
		.at_max     (third_low_max)
	);

	tmrs_cnt8 #(.W(8)) u_third_high (
		.clk        (clk),
		.nrst       (nrst),
		.inc        (third_high_inc),
		.reload_en  (third_wrap),
		.reload_val (reload_value_high_q),
		.count_q    (third_high_q),
		.at_max     (third_high_max)
	);

	assign third_count_q = {third_high_q, third_low_q};

	// ==========================================================
	// fourth timer: wide or split
	always_comb begin
		fourth_low_inc     = 1'b0;
		fourth_high_inc    = 1'b0;
		fourth_low_reload  = 1'b0;
		fourth_high_reload = 1'b0;
		case (mode)
			tmrs_pkg::TMRS_MODE_SPLIT: begin
				// low byte ignores run in split mode
				fourth_low_inc     = fourth_tick;
				fourth_high_inc    = fourth_tick && run_control_q;
				fourth_low_reload  = fourth_low_wrap;
				fourth_high_reload = fourth_high_wrap;
			end
			tmrs_pkg::TMRS_MODE_WIDE: begin
				fourth_low_inc     = fourth_tick && run_control_q;
				fourth_high_inc    = fourth_low_wrap;
				fourth_low_reload  = fourth_high_wrap;
				fourth_high_reload = fourth_high_wrap;
			end
			default: begin
				fourth_low_inc = 1'b0;
			end
		endcase
	end

	assign fourth_low_wrap  = fourth_low_inc && fourth_low_max;
	// in wide mode this is the 0xffff wrap, which reloads both bytes
	assign fourth_high_wrap = fourth_high_inc && fourth_high_max;

	tmrs_cnt8 #(.W(8)) u_fourth_low (
		.clk        (clk),
		.nrst       (nrst),
		.inc        (fourth_low_inc),
		.reload_en  (fourth_low_reload),
		.reload_val (fourth_reload_low),
		.count_q    (fourth_timer_low_byte_q),
		.at_max     (fourth_low_max)
	);

	tmrs_cnt8 #(.W(8)) u_fourth_high (
		.clk        (clk),
		.nrst       (nrst),
		.inc        (fourth_high_inc),
		.reload_en  (fourth_high_reload),
		.reload_val (fourth_reload_high),
		.count_q    (fourth_timer_high_byte_q),
		.at_max     (fourth_high_max)
	);

	// ==========================================================
	// register next values
	always_comb begin
		first_low_d  = wr_first ? sfr_wdata : first_timer_low_count_q;
		second_low_d = wr_second ? sfr_wdata : second_timer_low_count_q;
		reload_value_low_d  = wr_rl_low ? sfr_wdata
		                                : reload_value_low_q;
		reload_value_high_d = wr_rl_high ? sfr_wdata
		                                 : reload_value_high_q;
		high_overflow_flag_d      = high_overflow_flag_q;
		low_overflow_flag_d       = low_overflow_flag_q;
		low_overflow_irq_enable_d = low_overflow_irq_enable_q;
		capture_d                 = capture_mode_enable_q;
		split_mode_select_d       = split_mode_select_q;
		run_control_d             = run_control_q;
		xclk_d                    = external_clock_select_q;
		if (wr_ctrl) begin
			// software writes load the flags; a wrap below still sets them
			high_overflow_flag_d = sfr_wdata[`TMRS_BIT_HIGH_OVF];
			low_overflow_flag_d  = sfr_wdata[`TMRS_BIT_LOW_OVF];
			low_overflow_irq_enable_d = sfr_wdata[`TMRS_BIT_LOW_IRQ_EN];
			capture_d           = sfr_wdata[`TMRS_BIT_CAPTURE_EN];
			split_mode_select_d = sfr_wdata[`TMRS_BIT_SPLIT];
			run_control_d       = sfr_wdata[`TMRS_BIT_RUN];
			xclk_d = sfr_wdata[`TMRS_BIT_XCLK_HI:`TMRS_BIT_XCLK_LO];
		end
		// set wins over a clearing write in the same cycle
		if (fourth_high_wrap) begin
			high_overflow_flag_d = 1'b1;
		end
		if (fourth_low_wrap) begin
			low_overflow_flag_d = 1'b1;
		end
	end

	// ==========================================================
	// read path and interrupt request
	always_comb begin
		rdata_d = sfr_rdata_q;
		if (sfr_rd) begin
			case (sfr_addr)
				`TMRS_OFS_FIRST_LOW:   rdata_d = first_timer_low_count_q;
				`TMRS_OFS_SECOND_LOW:  rdata_d = second_timer_low_count_q;
				`TMRS_OFS_RELOAD_LOW:  rdata_d = reload_value_low_q;
				`TMRS_OFS_RELOAD_HIGH: rdata_d = reload_value_high_q;
				`TMRS_OFS_T3_CTRL: begin
					rdata_d = {high_overflow_flag_q,
					           low_overflow_flag_q,
					           low_overflow_irq_enable_q,
					           capture_mode_enable_q,
					           split_mode_select_q,
					           run_control_q,
					           external_clock_select_q};
				end
				default: rdata_d = `TMRS_RST_READ;
			endcase
		end
		// level request: holds while fourth_irq_enable and an enabled flag stay set
		irq_d = fourth_irq_enable &&
		        (high_overflow_flag_q ||
		         (low_overflow_flag_q && low_overflow_irq_enable_q));
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			first_timer_low_count_q   <= `TMRS_RST_BYTE;
			second_timer_low_count_q  <= `TMRS_RST_BYTE;
			reload_value_low_q        <= `TMRS_RST_BYTE;
			reload_value_high_q       <= `TMRS_RST_BYTE;
			high_overflow_flag_q      <= 1'b0;
			low_overflow_flag_q       <= 1'b0;
			low_overflow_irq_enable_q <= 1'b0;
			capture_mode_enable_q     <= 1'b0;
			split_mode_select_q       <= 1'b0;
			run_control_q             <= 1'b0;
			external_clock_select_q   <= 2'h0;
			sfr_rdata_q               <= `TMRS_RST_READ;
			fourth_irq_q              <= 1'b0;
		end else begin
			first_timer_low_count_q   <= first_low_d;
			second_timer_low_count_q  <= second_low_d;
			reload_value_low_q        <= reload_value_low_d;
			reload_value_high_q       <= reload_value_high_d;
			high_overflow_flag_q      <= high_overflow_flag_d;
			low_overflow_flag_q       <= low_overflow_flag_d;
			low_overflow_irq_enable_q <= low_overflow_irq_enable_d;
			capture_mode_enable_q     <= capture_d;
			split_mode_select_q       <= split_mode_select_d;
			run_control_q             <= run_control_d;
			external_clock_select_q   <= xclk_d;
			sfr_rdata_q               <= rdata_d;
			fourth_irq_q              <= irq_d;
		end
	end
endmodule : tmrs_top

`default_nettype wire

// >>> bench/tmrs_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// port checker
module tmrs_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// register port
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  sfr_rdata_q,
	input wire logic [7:0]  first_timer_low_count_q,
	// timers
	input wire logic        third_tick,
	input wire logic        third_run,
	input wire logic [15:0] third_count_q,
	input wire logic        fourth_tick,
	input wire logic [7:0]  fourth_reload_low,
	input wire logic [7:0]  fourth_reload_high,
	input wire logic        fourth_irq_enable,
	input wire logic [7:0]  fourth_timer_low_byte_q,
	input wire logic [7:0]  fourth_timer_high_byte_q,
	input wire logic        fourth_irq_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// shadow of software-only state; flags are not mirrored
	logic [7:0] lo_q, lo_d, hi_q, hi_d;
	logic [1:0] ctl_q, ctl_d;
	wire logic [7:0] lb = fourth_timer_low_byte_q;
	wire logic [7:0] hb = fourth_timer_high_byte_q;
	wire logic       tk = fourth_tick;

	always_comb begin
		lo_d = lo_q;
		hi_d = hi_q;
		ctl_d = ctl_q;
		if (sfr_wr && sfr_addr == 8'hca) lo_d = sfr_wdata;
		if (sfr_wr && sfr_addr == 8'hcb) hi_d = sfr_wdata;
		if (sfr_wr && sfr_addr == 8'h91) ctl_d = sfr_wdata[3:2];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lo_q <= 8'h00;
			hi_q <= 8'h00;
			ctl_q <= 2'h0;
		end else begin
			lo_q <= lo_d;
			hi_q <= hi_d;
			ctl_q <= ctl_d;
		end
	end

	property p_first_wr;
		sfr_wr && sfr_addr == 8'h8a |=>
			first_timer_low_count_q == $past(sfr_wdata);
	endproperty
	a_first_wr: assert property (p_first_wr)
		else $error("first low byte write lost");
	property p_rl_lo;
		sfr_rd && sfr_addr == 8'hca |=> sfr_rdata_q == $past(lo_q);
	endproperty
	a_rl_lo: assert property (p_rl_lo) else $error("reload low bad");
	property p_rl_hi;
		sfr_rd && sfr_addr == 8'hcb |=> sfr_rdata_q == $past(hi_q);
	endproperty
	a_rl_hi: assert property (p_rl_hi) else $error("reload high bad");
	property p_irq_en;
		!fourth_irq_enable |=> !fourth_irq_q;
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq not gated");
	property p_low_reload;
		// only split mode reloads the low byte on its own wrap
		ctl_q[1] && tk && lb == 8'hff |=> lb == $past(fourth_reload_low);
	endproperty
	a_low_reload: assert property (p_low_reload)
		else $error("low byte reload wrong");
	property p_split_low;
		ctl_q[1] && tk && lb != 8'hff |=> lb == $past(lb) + 8'h01;
	endproperty
	a_split_low: assert property (p_split_low)
		else $error("split low byte not counting");
	property p_stop;
		ctl_q == 2'b00 |=> $stable(lb) && $stable(hb);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped timer moved");
	property p_wide_carry;
		ctl_q == 2'b01 && tk && lb == 8'hff && hb != 8'hff |=>
			hb == $past(hb) + 8'h01;
	endproperty
	a_wide_carry: assert property (p_wide_carry)
		else $error("wide carry missing");
	property p_third;
		third_tick && third_run && third_count_q == 16'hffff |=>
			third_count_q == $past({hi_q, lo_q});
	endproperty
	a_third: assert property (p_third) else $error("third reload bad");
	property p_wide_wrap;
		ctl_q == 2'b01 && tk && lb == 8'hff && hb == 8'hff |=>
			lb == $past(fourth_reload_low) && hb == $past(fourth_reload_high);
	endproperty
	a_wide_wrap: assert property (p_wide_wrap)
		else $error("wide wrap reload wrong");
	property p_irq_high;
		ctl_q == 2'b11 && tk && hb == 8'hff ##1 fourth_irq_enable |=>
			fourth_irq_q;
	endproperty
	a_irq_high: assert property (p_irq_high)
		else $error("high overflow irq missing");
endmodule : tmrs_chk

bind tmrs_top tmrs_chk u_chk (
	.clk                      (clk),
	.nrst                     (nrst),
	.sfr_addr                 (sfr_addr),
	.sfr_wr                   (sfr_wr),
	.sfr_rd                   (sfr_rd),
	.sfr_wdata                (sfr_wdata),
	.sfr_rdata_q              (sfr_rdata_q),
	.first_timer_low_count_q  (first_timer_low_count_q),
	.third_tick               (third_tick),
	.third_run                (third_run),
	.third_count_q            (third_count_q),
	.fourth_tick              (fourth_tick),
	.fourth_reload_low        (fourth_reload_low),
	.fourth_reload_high       (fourth_reload_high),
	.fourth_irq_enable        (fourth_irq_enable),
	.fourth_timer_low_byte_q  (fourth_timer_low_byte_q),
	.fourth_timer_high_byte_q (fourth_timer_high_byte_q),
	.fourth_irq_q             (fourth_irq_q)
);

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// self-checking bench
module testbench;
	logic       clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, d;
	logic       third_tick = 1'b1, third_run = 1'b1, rd_p = 1'b0;
	logic       fourth_tick = 1'b0, fourth_irq_enable = 1'b0;
	logic [7:0] fourth_reload_low = 8'hfe, fourth_reload_high = 8'hfe;
	wire logic [7:0]  sfr_rdata_q, first_timer_low_count_q;
	wire logic [7:0]  second_timer_low_count_q;
	wire logic [7:0]  fourth_timer_low_byte_q, fourth_timer_high_byte_q;
	wire logic [1:0]  external_clock_select_q;
	wire logic        capture_mode_enable_q, fourth_irq_q;
	wire logic [15:0] third_count_q;
	int         n_errors = 0, checks = 0, cycles = 0, i;
	logic [7:0] exp_q[$];
	logic [7:0] ra[6] = '{8'h8a, 8'h8b, 8'h91, 8'hca, 8'hcb, 8'h55};

	tmrs_top DUT (
		.clk                      (clk),
		.nrst                     (nrst),
		.sfr_addr                 (sfr_addr),
		.sfr_wr                   (sfr_wr),
		.sfr_rd                   (sfr_rd),
		.sfr_wdata                (sfr_wdata),
		.sfr_rdata_q              (sfr_rdata_q),
		.third_tick               (third_tick),
		.third_run                (third_run),
		.fourth_tick              (fourth_tick),
		.fourth_reload_low        (fourth_reload_low),
		.fourth_reload_high       (fourth_reload_high),
		.fourth_irq_enable        (fourth_irq_enable),
		.first_timer_low_count_q  (first_timer_low_count_q),
		.second_timer_low_count_q (second_timer_low_count_q),
		.external_clock_select_q  (external_clock_select_q),
		.capture_mode_enable_q    (capture_mode_enable_q),
		.third_count_q            (third_count_q),
		.fourth_timer_low_byte_q  (fourth_timer_low_byte_q),
		.fourth_timer_high_byte_q (fourth_timer_high_byte_q),
		.fourth_irq_q             (fourth_irq_q)
	);

	always #2.5 clk = ~clk;

	task cmp(input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp
	task final_report;
		$display("checks=%0d errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask : wr
	// expectation noted first, checked by the read monitor
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
	endtask : rd
	task run4(input int n);
		@(posedge clk);
		fourth_tick <= 1'b1;
		repeat (n) @(posedge clk);
		fourth_tick <= 1'b0;
	endtask : run4
	// irq is a flop: sampled mid-cycle, well after its edge
	task irq_is(input logic en, input logic e);
		@(posedge clk);
		fourth_irq_enable <= en;
		repeat (3) @(posedge clk);
		@(negedge clk);
		cmp({7'h00, e}, {7'h00, fourth_irq_q});
	endtask : irq_is

	always @(posedge clk) rd_p <= sfr_rd;
	always @(negedge clk) if (rd_p) cmp(exp_q.pop_front(), sfr_rdata_q);
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_errors++;
			final_report();
		end
	end

	initial begin
		void'($urandom(32'h40d91ab0));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		foreach (ra[k]) rd(ra[k], 8'h00);
		for (i = 0; i < 4; i++) begin
			d = 8'($urandom);
			wr(ra[i < 2 ? i : i + 1], d);
			rd(ra[i < 2 ? i : i + 1], d);
			if (i == 0) cmp(d, first_timer_low_count_q);
			if (i == 1) cmp(d, second_timer_low_count_q);
		end
		wr(8'h55, 8'hff);
		rd(8'h55, 8'h00);
		wr(8'hca, 8'hf0);
		wr(8'hcb, 8'hff);
		$display("test registers done");
		wr(8'h91, 8'h08);
		run4(300);
		rd(8'h91, 8'h48);
		cmp(8'h00, fourth_timer_high_byte_q);
		irq_is(1'b1, 1'b0);
		wr(8'h91, 8'h68);
		irq_is(1'b1, 1'b1);
		$display("test split low done");
		wr(8'h91, 8'h0c);
		run4(300);
		rd(8'h91, 8'hcc);
		irq_is(1'b1, 1'b1);
		irq_is(1'b0, 1'b0);
		irq_is(1'b1, 1'b1);
		rd(8'h91, 8'hcc);
		$display("test split high done");
		wr(8'h91, 8'h04);
		run4(300);
		rd(8'h91, 8'hc4);
		// stopped wide timer, with capture and clock select bits stored
		wr(8'h91, 8'h13);
		run4(300);
		rd(8'h91, 8'h13);
		irq_is(1'b1, 1'b0);
		cmp(8'h01, {7'h00, capture_mode_enable_q});
		cmp(8'h03, {6'h00, external_clock_select_q});
		$display("test wide done");
		// sampled mid-cycle so the count has settled after its edge
		for (i = 0; i < 70000 && third_count_q !== 16'hffff; i++)
			@(negedge clk);
		@(negedge clk);
		cmp(8'hf0, third_count_q[7:0]);
		cmp(8'hff, third_count_q[15:8]);
		rd(8'hca, 8'hf0);
		$display("test third reload done");
		final_report();
	end
endmodule : testbench

`default_nettype wire
